// ==== byte_rotate_unit.sv ====
`timescale 1ns/100ps
module byte_rotate_unit
  import byte_rotate_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clock_en,
  input wire rot_req_s i_req,
  output rot_res_s o_res
);

  // all state of the unit
  typedef struct packed {
    rot_res_s res;
  } state_s;

  // what one operation code asks of the datapath
  typedef struct packed {
    logic legal; // one of the six rotate codes
    logic to_mem; // result goes back to the memory byte
    logic to_acc; // result goes to the accumulator
    logic thru_carry; // carry flag takes part in the rotate
    logic left; // rotate toward the top bit
  } op_flags_s;

  // state after reset: no strobes, result and carry cleared
  localparam state_s STATE_RESET = '{
    res: '{
      mem_we: 1'b0,
      acc_we: 1'b0,
      carry_we: 1'b0,
      result: DATA_RESET,
      carry: CARRY_RESET
    }
  };

  // decode an operation code into its datapath flags
  function automatic op_flags_s decode_op(input rot_op_e op);
    op_flags_s flags;
    flags = '{legal: 1'b0, to_mem: 1'b0, to_acc: 1'b0, thru_carry: 1'b0, left: 1'b0};
    unique case (op)
      // left through carry, back to memory
      rot_left_cy_mem: begin
        flags.legal = 1'b1;
        flags.to_mem = 1'b1;
        flags.thru_carry = 1'b1;
        flags.left = 1'b1;
      end

      // left through carry, into the accumulator
      rot_left_cy_acc: begin
        flags.legal = 1'b1;
        flags.to_acc = 1'b1;
        flags.thru_carry = 1'b1;
        flags.left = 1'b1;
      end

      // plain right, back to memory
      rot_right_mem: begin
        flags.legal = 1'b1;
        flags.to_mem = 1'b1;
      end

      // plain right, into the accumulator
      rot_right_acc: begin
        flags.legal = 1'b1;
        flags.to_acc = 1'b1;
      end

      // right through carry, back to memory
      rot_right_cy_mem: begin
        flags.legal = 1'b1;
        flags.to_mem = 1'b1;
        flags.thru_carry = 1'b1;
      end

      // right through carry, into the accumulator
      rot_right_cy_acc: begin
        flags.legal = 1'b1;
        flags.to_acc = 1'b1;
        flags.thru_carry = 1'b1;
      end

      default: begin
        flags.legal = 1'b0; // codes 6 and 7 write nothing
      end
    endcase
    return flags;
  endfunction : decode_op

  // carry after the rotate
  function automatic logic carry_after(
    input op_flags_s flags,
    input logic [DATA_W-1:0] operand,
    input logic carry_in
  );
    logic carry_next;
    carry_next = carry_in; // plain rotates keep the old carry
    if (flags.legal && flags.thru_carry) begin
      // the bit pushed out of the byte becomes the carry
      if (flags.left) begin
        carry_next = operand[MSB_POS];
      end else begin
        carry_next = operand[LSB_POS];
      end
    end
    return carry_next;
  endfunction : carry_after

  // bit that enters the free end of the byte
  function automatic logic fill_bit(
    input op_flags_s flags,
    input logic [DATA_W-1:0] operand,
    input logic carry_in
  );
    logic fill;
    fill = carry_in; // through-carry rotates feed the old carry in
    if (!flags.thru_carry) begin
      // plain rotates wrap the bit that falls off
      if (flags.left) begin
        fill = operand[MSB_POS];
      end else begin
        fill = operand[LSB_POS];
      end
    end
    return fill;
  endfunction : fill_bit

  // bits that move up one place on a left rotate
  logic [DATA_W-2:0] up_bits;
  // bits that move down one place on a right rotate
  logic [DATA_W-2:0] down_bits;

  // one wire per moving bit; the free end is filled apart
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W - 1; gi++) begin : g_shift
      assign up_bits[gi] = i_req.operand[gi]; // lands in bit gi+1
      assign down_bits[gi] = i_req.operand[gi + 1]; // lands in bit gi
    end
  endgenerate

  // decoded request and the bits that cross an end
  op_flags_s op_flags;
  logic fill_in;
  logic carry_new;

  assign op_flags = decode_op(i_req.op);
  assign fill_in = fill_bit(op_flags, i_req.operand, i_req.carry);
  assign carry_new = carry_after(op_flags, i_req.operand, i_req.carry);

  // whole byte for each direction
  logic [DATA_W-1:0] left_byte;
  logic [DATA_W-1:0] right_byte;

  assign left_byte = {up_bits, fill_in};
  assign right_byte = {fill_in, down_bits};

  // registered state and its next value
  state_s state;
  state_s next_state;

  // compute one operation per accepted request
  always_comb begin
    next_state = state;
    // write strobes stand for one enabled cycle only
    next_state.res.mem_we = 1'b0;
    next_state.res.acc_we = 1'b0;
    next_state.res.carry_we = 1'b0;
    if (i_req.valid && op_flags.legal) begin
      unique case (i_req.op)
        rot_left_cy_mem: begin
          next_state.res.result = left_byte; // old carry enters bit 0
        end
        rot_left_cy_acc: begin
          next_state.res.result = left_byte;
        end
        rot_right_mem: begin
          next_state.res.result = right_byte; // bit 0 wraps to bit 7
        end
        rot_right_acc: begin
          next_state.res.result = right_byte;
        end
        rot_right_cy_mem: begin
          next_state.res.result = right_byte; // old carry enters bit 7
        end
        rot_right_cy_acc: begin
          next_state.res.result = right_byte;
        end
        default: begin
          next_state.res.result = state.res.result; // codes 6 and 7 change nothing
        end
      endcase
      next_state.res.carry = carry_new;
      next_state.res.mem_we = op_flags.to_mem;
      next_state.res.acc_we = op_flags.to_acc;
      next_state.res.carry_we = op_flags.thru_carry;
    end
  end

  // register the state; clock enable low freezes it all
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state <= STATE_RESET;
    end else if (i_clock_en) begin
      state <= next_state;
    end
  end

  // outputs straight from the state flops
  assign o_res = state.res;

endmodule : byte_rotate_unit

// ==== byte_rotate_pkg.sv ====
// Notes on behaviour
// - left through carry, result to memory
// - left through carry, result to accumulator
// - plain right rotate, result to memory
// - plain right rotate to accumulator, flags kept
// - right through carry, result to memory
// - right through carry, result to accumulator
package byte_rotate_pkg;

  localparam int DATA_W = 8;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic CARRY_RESET = 1'b0;
  localparam int MSB_POS = DATA_W - 1; // top bit of a byte
  localparam int LSB_POS = 0; // bottom bit of a byte

  // operation select from the instruction decoder
  typedef enum logic [2:0] {
    rot_left_cy_mem,
    rot_left_cy_acc,
    rot_right_mem,
    rot_right_acc,
    rot_right_cy_mem,
    rot_right_cy_acc
  } rot_op_e;

  // one request from the decoder
  typedef struct packed {
    logic valid;
    rot_op_e op;
    logic [DATA_W-1:0] operand;
    logic carry;
  } rot_req_s;

  // one answer toward memory, accumulator and carry
  typedef struct packed {
    logic mem_we;
    logic acc_we;
    logic carry_we;
    logic [DATA_W-1:0] result;
    logic carry;
  } rot_res_s;

endpackage : byte_rotate_pkg

// ==== byte_rotate_unit_asserts.sv ====
`timescale 1ns/100ps
module rot_chk
  import byte_rotate_pkg::*;
(
  input logic i_clock,
  input logic i_rst,
  input logic i_clock_en,
  input rot_req_s i_req,
  input rot_res_s o_res
);
  // left through carry to memory: bit 7 to carry, old carry to bit 0
  property p_left_cy_mem;
    @(posedge i_clock) disable iff (i_rst)
    i_clock_en && i_req.valid && i_req.op == rot_left_cy_mem |=>
      o_res.mem_we && !o_res.acc_we && o_res.carry_we &&
      {o_res.carry, o_res.result} == {$past(i_req.operand), $past(i_req.carry)};
  endproperty
  a_left_cy_mem: assert property (p_left_cy_mem) else $error("left rotate through carry to memory wrong");

  // left through carry to accumulator: memory not written
  property p_left_cy_acc;
    @(posedge i_clock) disable iff (i_rst)
    i_clock_en && i_req.valid && i_req.op == rot_left_cy_acc |=>
      !o_res.mem_we && o_res.acc_we && o_res.carry_we &&
      {o_res.carry, o_res.result} == {$past(i_req.operand), $past(i_req.carry)};
  endproperty
  a_left_cy_acc: assert property (p_left_cy_acc) else $error("left rotate through carry to accumulator wrong");

  // plain right to memory: bit 0 wraps to bit 7, carry untouched
  property p_right_mem;
    @(posedge i_clock) disable iff (i_rst)
    i_clock_en && i_req.valid && i_req.op == rot_right_mem |=>
      o_res.mem_we && !o_res.acc_we && !o_res.carry_we && o_res.carry == $past(i_req.carry) &&
      o_res.result == {$past(i_req.operand[0]), $past(i_req.operand[7:1])};
  endproperty
  a_right_mem: assert property (p_right_mem) else $error("plain right rotate to memory wrong");

  // plain right to accumulator: memory and carry untouched
  property p_right_acc;
    @(posedge i_clock) disable iff (i_rst)
    i_clock_en && i_req.valid && i_req.op == rot_right_acc |=>
      !o_res.mem_we && o_res.acc_we && !o_res.carry_we && o_res.carry == $past(i_req.carry) &&
      o_res.result == {$past(i_req.operand[0]), $past(i_req.operand[7:1])};
  endproperty
  a_right_acc: assert property (p_right_acc) else $error("plain right rotate to accumulator wrong");

  // right through carry to memory: bit 0 to carry, old carry to bit 7
  property p_right_cy_mem;
    @(posedge i_clock) disable iff (i_rst)
    i_clock_en && i_req.valid && i_req.op == rot_right_cy_mem |=>
      o_res.mem_we && !o_res.acc_we && o_res.carry_we &&
      {o_res.result, o_res.carry} == {$past(i_req.carry), $past(i_req.operand)};
  endproperty
  a_right_cy_mem: assert property (p_right_cy_mem) else $error("right rotate through carry to memory wrong");

  // right through carry to accumulator: memory not written
  property p_right_cy_acc;
    @(posedge i_clock) disable iff (i_rst)
    i_clock_en && i_req.valid && i_req.op == rot_right_cy_acc |=>
      !o_res.mem_we && o_res.acc_we && o_res.carry_we &&
      {o_res.result, o_res.carry} == {$past(i_req.carry), $past(i_req.operand)};
  endproperty
  a_right_cy_acc: assert property (p_right_cy_acc) else $error("right rotate through carry to accumulator wrong");

  // no request or an unused code: no write strobe on the next cycle
  property p_idle;
    @(posedge i_clock) disable iff (i_rst)
    i_clock_en && (!i_req.valid || i_req.op > rot_right_cy_acc) |=>
      !o_res.mem_we && !o_res.acc_we && !o_res.carry_we;
  endproperty
  a_idle: assert property (p_idle) else $error("write strobe without a rotate");

  // clock enable low holds every output
  property p_hold;
    @(posedge i_clock) disable iff (i_rst)
    !i_clock_en |=> $stable(o_res);
  endproperty
  a_hold: assert property (p_hold) else $error("outputs moved while clock enable low");
endmodule : rot_chk
bind byte_rotate_unit rot_chk u_chk (.i_clock(i_clock), .i_rst(i_rst), .i_clock_en(i_clock_en),
  .i_req(i_req), .o_res(o_res));

// ==== core_model.sv ====
`timescale 1ns/100ps
module core_model
  import byte_rotate_pkg::*;
(
  input logic i_clock,
  input rot_res_s i_res,
  output logic [16:0] o_st = 17'h12C01
);
  // memory, accumulator and carry take the write pulses
  always @(posedge i_clock) begin
    if (i_res.mem_we) o_st[16:9] <= i_res.result;
    if (i_res.acc_we) o_st[8:1] <= i_res.result;
    if (i_res.carry_we) o_st[0] <= i_res.carry;
  end
endmodule : core_model

// ==== tb_top.sv ====
`timescale 1ns/100ps
module tb_top
  import byte_rotate_pkg::*;
;
`define CK(a, b) checked++; if ((a) !== (b)) begin num_errors++; $display("unexpected %0t state", $time); end
  localparam int MAX_CYCLES = 200; // tests take about 40 cycles
  logic clk = 0, rst = 1, en = 1, valid = 0;
  logic [2:0] op = 0;
  rot_res_s res;
  wire [16:0] st;
  int num_errors = 0, checked = 0, cycles = 0;
  // clock_en, op, then memory, accumulator, carry
  logic [20:0] rows [8] = '{21'h105A01, 21'h125AB6, 21'h152CB6, 21'h172C96, 21'h189696, 21'h1A964B, 21'h00964B, 21'h1C964B};
  always #4 clk = ~clk;
  byte_rotate_unit DUT (.i_clock(clk), .i_rst(rst), .i_clock_en(en), .i_req({valid, op, st[16:9], st[0]}),
    .o_res(res));
  core_model pm (.i_clock(clk), .i_res(res), .o_st(st));
  task results;
    $display("%0d errors %0d checks", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  // hang guard: cycle count with a ceiling
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == MAX_CYCLES) begin
      num_errors++;
      results;
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 0;
    foreach (rows[k]) begin
      {en, op} = rows[k][20:17];
      valid = 1;
      @(negedge clk) valid = 0;
      repeat (2) @(negedge clk);
      `CK(st, rows[k][16:0])
      $display("row %0d done", k);
    end
    // mid-run reset clears strobes, result and carry
    rst = 1;
    @(negedge clk);
    `CK(res, {3'b000, DATA_RESET, CARRY_RESET})
    $display("reset test done");
    // request taken on the first edge after release
    rst = 0;
    op = rot_right_cy_acc;
    valid = 1;
    @(negedge clk);
    valid = 0;
    `CK(res, {3'b011, 8'hA5, 1'b1})
    @(negedge clk);
    `CK(res, {3'b000, 8'hA5, 1'b1})
    $display("first request after reset done");
    // clock enable low holds the write strobe
    op = rot_right_mem;
    valid = 1;
    @(negedge clk);
    en = 0;
    valid = 0;
    repeat (2) @(negedge clk);
    `CK(res, {3'b100, 8'hA5, 1'b1})
    en = 1;
    repeat (2) @(negedge clk);
    `CK(st, {8'hA5, 8'hA5, 1'b1})
    `CK(res.mem_we, 1'b0)
    $display("clock enable test done");
    results;
  end
endmodule : tb_top
